// ---- hdl/cem_defines.vh ----
// Purpose: constants shared by the counter / encoder / edge-measure block
// Assumes: included by bare name from design files
// Notes: definitions only
`ifndef CEM_DEFINES_VH
`define CEM_DEFINES_VH

// ==========================================================================
// modes
`define CEM_MODE_X1 3'h0
`define CEM_MODE_X2 3'h1
`define CEM_MODE_X4 3'h2
`define CEM_MODE_TWO_PULSE 3'h3
`define CEM_MODE_EDGE_SEP 3'h4

// ==========================================================================
// edge-separation states
`define CEM_ST_IDLE 2'h0
`define CEM_ST_WAIT_START 2'h1
`define CEM_ST_COUNT 2'h2
`define CEM_ST_DONE 2'h3

// ==========================================================================
// synchroniser bit positions
`define CEM_IN_A 0
`define CEM_IN_B 1
`define CEM_IN_IDX 2
`define CEM_IN_START 3
`define CEM_IN_GATE 4
`define CEM_IN_SRC 5
`define CEM_IN_SAMPLE 6
`define CEM_NSYNC 7

// ==========================================================================
// defaults
`define CEM_COUNT_WIDTH 32
`define CEM_FIFO_DEPTH 4
`define CEM_FIFO_AW 2

`endif

// ---- hdl/cem_fifo.v ----
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes: DEPTH must be a power of two matching AW
`timescale 1ns/100ps
module cem_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // drain side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW:0] wr_q;
    reg [AW:0] rd_q;
    wire full;
    wire empty;
    wire do_wr;
    wire do_rd;

    assign empty = (wr_q == rd_q);
    assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
    assign in_ready_o = ~full;
    assign out_valid_o = ~empty;
    assign do_wr = in_valid_i & ~full;
    assign do_rd = out_ready_i & ~empty;
    assign out_data_o = mem_q[rd_q[AW-1:0]];

    always @(posedge clock_i) begin
        if (do_wr) begin
            mem_q[wr_q[AW-1:0]] <= in_data_i;
        end
    end

    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_q <= wr_q + 1'b1;
            end
            if (do_rd) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

endmodule // cem_fifo

// ---- hdl/cem_counter.v ----
// Purpose: position counter (quadrature X1/X2/X4, two-pulse) and
//          two-signal edge-separation measurement
// Assumes: all external inputs asynchronous, two-stage synchronised here
// Notes: saved values are pushed through a small FIFO toward DMA
`timescale 1ns/100ps
`include "cem_defines.vh"
module cem_counter #(
    parameter CW = `CEM_COUNT_WIDTH,
    parameter FIFO_DEPTH = `CEM_FIFO_DEPTH,
    parameter FIFO_AW = `CEM_FIFO_AW
) (
    // clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // control
    input wire arm_i,
    input wire [2:0] mode_i,
    input wire buffered_i,
    input wire [CW-1:0] reload_value_i,
    input wire [1:0] reload_phase_i,
    input wire reload_en_i,
    input wire start_rising_i,
    input wire gate_rising_i,
    input wire source_rising_i,
    input wire gate_from_pulse_i,
    // external signals
    input wire chan_a_i,
    input wire chan_b_i,
    input wire index_i,
    input wire start_edge_i,
    input wire gate_i,
    input wire source_i,
    input wire neighbour_pulse_i,
    input wire sample_clk_i,
    // status and results
    output wire [CW-1:0] count_o,
    output wire [CW-1:0] saved_o,
    output wire saved_valid_o,
    output wire [1:0] sep_state_o,
    output wire overflow_o,
    // buffered output toward dma
    output wire buf_valid_o,
    input wire buf_ready_i,
    output wire [CW-1:0] buf_data_o
);

    // ======================================================================
    // input synchronisers
    localparam NSYNC = `CEM_NSYNC;
    wire [NSYNC-1:0] raw_in;
    wire gate_src;
    reg [NSYNC-1:0] s1_q;
    reg [NSYNC-1:0] s2_q;
    reg [NSYNC-1:0] s3_q;
    wire [NSYNC-1:0] rise;
    wire [NSYNC-1:0] fall;

    assign gate_src = gate_from_pulse_i ? neighbour_pulse_i : gate_i;
    assign raw_in = {sample_clk_i, source_i, gate_src, start_edge_i, index_i, chan_b_i,
        chan_a_i};

    // first stage feeds only the second, so a metastable level never
    // reaches the edge detectors
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge clock_i) begin
                if (!rst_n_i) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= raw_in[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                end
            end
            // edges judged only between second and third stage
            assign rise[gi] = s2_q[gi] & ~s3_q[gi];
            assign fall[gi] = ~s2_q[gi] & s3_q[gi];
        end
    endgenerate

    wire a_rise = rise[`CEM_IN_A];
    wire a_fall = fall[`CEM_IN_A];
    wire b_rise = rise[`CEM_IN_B];
    wire b_fall = fall[`CEM_IN_B];
    wire a_now = s2_q[`CEM_IN_A];
    wire b_now = s2_q[`CEM_IN_B];
    wire a_old = s3_q[`CEM_IN_A];
    wire b_old = s3_q[`CEM_IN_B];
    wire idx_now = s2_q[`CEM_IN_IDX];
    // polarity only picks which edge of the synchronised level counts
    wire start_hit = start_rising_i ? rise[`CEM_IN_START] : fall[`CEM_IN_START];
    wire gate_hit = gate_rising_i ? rise[`CEM_IN_GATE] : fall[`CEM_IN_GATE];
    wire src_hit = source_rising_i ? rise[`CEM_IN_SRC] : fall[`CEM_IN_SRC];
    wire sample_hit = rise[`CEM_IN_SAMPLE];

    // ======================================================================
    // quadrature direction
    // A leads when, on an A edge, A's new level differs from B; on a B edge,
    // B's new level equals A
    wire a_edge = a_rise | a_fall;
    wire b_edge = b_rise | b_fall;
    reg step_up;
    reg step_dn;
    reg [CW-1:0] count_q;
    reg [CW-1:0] count_d;
    reg [CW-1:0] saved_q;
    reg saved_valid_q;
    reg armed_q;
    reg [1:0] st_q;
    reg [1:0] st_d;
    reg save_now;

    always @* begin
        step_up = 1'b0;
        step_dn = 1'b0;
        case (mode_i)
            `CEM_MODE_X1: begin
                step_up = a_rise & ~b_now;
                step_dn = a_fall & ~b_now;
            end
            `CEM_MODE_X2: begin
                step_up = a_edge & (a_now != b_now);
                step_dn = a_edge & (a_now == b_now);
            end
            `CEM_MODE_X4: begin
                // simultaneous A and B edges are illegal and ignored
                step_up = (a_edge & ~b_edge & (a_now != b_now)) |
                    (b_edge & ~a_edge & (a_now == b_now));
                step_dn = (a_edge & ~b_edge & (a_now == b_now)) |
                    (b_edge & ~a_edge & (a_now != b_now));
            end
            `CEM_MODE_TWO_PULSE: begin
                // both rising together cancel out
                step_up = a_rise & ~b_rise;
                step_dn = b_rise & ~a_rise;
            end
            default: begin
                step_up = 1'b0;
                step_dn = 1'b0;
            end
        endcase
    end

    // ======================================================================
    // index reload
    // the phase check uses the settled levels, so a step entering the phase
    // lands first and the reload takes the following edge
    wire quad_mode = (mode_i == `CEM_MODE_X1) || (mode_i == `CEM_MODE_X2) ||
        (mode_i == `CEM_MODE_X4);
    wire in_phase = ({a_old, b_old} == reload_phase_i) &&
        ({a_now, b_now} == reload_phase_i);
    wire reload_now = armed_q & quad_mode & reload_en_i & in_phase & idx_now &
        ~step_up & ~step_dn;

    // ======================================================================
    // edge-separation sequencer
    always @* begin
        st_d = st_q;
        save_now = 1'b0;
        case (st_q)
            `CEM_ST_IDLE: begin
                if (armed_q && mode_i == `CEM_MODE_EDGE_SEP) begin
                    st_d = `CEM_ST_WAIT_START;
                end
            end
            `CEM_ST_WAIT_START: begin
                if (start_hit) begin
                    st_d = `CEM_ST_COUNT;
                end
            end
            `CEM_ST_COUNT: begin
                if (gate_hit) begin
                    save_now = 1'b1;
                    st_d = buffered_i ? `CEM_ST_WAIT_START : `CEM_ST_DONE;
                end
            end
            `CEM_ST_DONE: begin
                // single mode parks here until arm drops or the mode leaves edge-separation
                st_d = `CEM_ST_DONE;
            end
            default: begin
                st_d = `CEM_ST_IDLE;
            end
        endcase
        // disarming always falls back to idle; leaving edge-separation does too unless a buffered restart fires that cycle
        if (!armed_q || mode_i != `CEM_MODE_EDGE_SEP) begin
            st_d = `CEM_ST_IDLE;
            save_now = 1'b0;
        end
    end

    // buffered restart: next gate edge opens a new interval
    wire sep_counting = (st_q == `CEM_ST_COUNT);
    wire restart_hit = buffered_i & (st_q == `CEM_ST_WAIT_START) & gate_hit &
        saved_valid_q;

    // ======================================================================
    // counter
    wire sep_mode = (mode_i == `CEM_MODE_EDGE_SEP);
    // steps outrank the reload, so an edge entering the reload phase
    // is counted before the value is loaded
    always @* begin
        count_d = count_q;
        if (!armed_q) begin
            count_d = count_q;
        end else if (sep_mode) begin
            if (save_now) begin
                count_d = {CW{1'b0}};
            end else if (sep_counting && src_hit) begin
                count_d = count_q + 1'b1;
            end else if (!sep_counting) begin
                // every interval starts from zero, whatever the encoder left
                count_d = {CW{1'b0}};
            end
        end else if (step_up) begin
            count_d = count_q + 1'b1;
        end else if (step_dn) begin
            count_d = count_q - 1'b1;
        end else if (reload_now) begin
            count_d = reload_value_i;
        end
    end

    // ======================================================================
    // capture into buffer
    // the buffer takes count_q, the value before this edge's update;
    // a capture and a step in one cycle records the older count
    wire sample_cap = armed_q & ~sep_mode & buffered_i & sample_hit;
    wire push = save_now | sample_cap;
    wire push_ready;
    reg overflow_q;

    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            armed_q <= 1'b0;
            st_q <= `CEM_ST_IDLE;
            count_q <= {CW{1'b0}};
            saved_q <= {CW{1'b0}};
            saved_valid_q <= 1'b0;
            overflow_q <= 1'b0;
        end else begin
            armed_q <= arm_i;
            st_q <= restart_hit ? `CEM_ST_COUNT : st_d;
            count_q <= count_d;
            if (!arm_i) begin
                saved_valid_q <= 1'b0;
                overflow_q <= 1'b0;
            end else if (save_now) begin
                saved_q <= count_q;
                saved_valid_q <= 1'b1;
            end
            // a full buffer drops the capture and flags it
            if (push && !push_ready && arm_i) begin
                overflow_q <= 1'b1;
            end
        end
    end

    cem_fifo #(
        .WIDTH(CW),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(push),
        .in_ready_o(push_ready),
        .in_data_i(count_q),
        .out_valid_o(buf_valid_o),
        .out_ready_i(buf_ready_i),
        .out_data_o(buf_data_o)
    );

    assign count_o = count_q;
    assign saved_o = saved_q;
    assign saved_valid_o = saved_valid_q;
    assign sep_state_o = st_q;
    assign overflow_o = overflow_q;

endmodule // cem_counter

// ---- test/cem_enc_model.sv ----
// Purpose: far-side model: encoder A/B, index, start, gate, source, pulse
// Assumes: the bench calls the tasks; each level stands 6 cycles
// Notes: sig_o bits 6 pulse, 5 source, 4 gate, 3 start, 2 index, 1 b, 0 a
`timescale 1ns/100ps
module cem_enc_model (
    // clock
    input wire clock_i,
    // far-side signals
    output reg [6:0] sig_o
);
    reg [1:0] ph_q;
    initial begin
        sig_o = 7'h00;
        ph_q = 2'h0;
    end
    // ====================
    // stimulus tasks
    // 6 cycles a level keeps A and B edges apart after the sync stages
    task hold(input [6:0] v);
        begin
            @(posedge clock_i);
            #1;
            sig_o = v;
            repeat (6) @(posedge clock_i);
            #1;
        end
    endtask
    // up walk on a,b: 00 10 11 01, so A leads
    task step(input up);
        begin
            ph_q = up ? ph_q + 2'h1 : ph_q - 2'h1;
            hold({sig_o[6:2], ph_q[1], ^ph_q});
        end
    endtask
    task pulse(input integer k);
        begin
            hold(sig_o | (7'h01 << k));
            hold(sig_o & ~(7'h01 << k));
        end
    endtask
    // index only inside the reload phase, else no reload can happen
    task index_pulse(input [1:0] want);
        begin
            if ({sig_o[0], sig_o[1]} == want) pulse(2);
        end
    endtask
endmodule // cem_enc_model

// ---- test/cem_counter_asserts.sv ----
// Purpose: port assertions for cem_counter
// Assumes: one clock domain, bound below
// Notes: run_q skips the cycles around arm changes
`timescale 1ns/100ps
module cem_counter_chk #(
    parameter CW = 32
) (
    // clock and reset
    input wire clock_i,
    input wire rst_n_i,
    // inputs
    input wire arm_i,
    input wire [2:0] mode_i,
    input wire buffered_i,
    input wire reload_en_i,
    input wire chan_a_i,
    input wire chan_b_i,
    input wire sample_clk_i,
    input wire buf_ready_i,
    // outputs
    input wire [CW-1:0] count_o,
    input wire [CW-1:0] saved_o,
    input wire saved_valid_o,
    input wire [1:0] sep_state_o,
    input wire buf_valid_o
);
    reg [2:0] run_q;
    wire [2:0] run_d = arm_i ? run_q + {2'h0, run_q != 3'h7} : 3'h0;
    always @(posedge clock_i) begin
        run_q <= rst_n_i ? run_d : 3'h0;
    end
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    // ====================
    // properties
    property p_idle; !arm_i [*3] |=> $stable(count_o); endproperty
    a_idle: assert property (p_idle) else $error("count moved unarmed");
    property p_unit; run_q > 3'h3 && mode_i < 3'h4 && $stable(mode_i) && !reload_en_i &&
        $changed(count_o) |-> count_o - $past(count_o) == 1 || $past(count_o) - count_o == 1;
    endproperty
    a_unit: assert property (p_unit) else $error("step not one");
    property p_x1; run_q > 3'h3 && mode_i == 3'h0 && $stable(mode_i) && !reload_en_i &&
        $changed(count_o) |-> !chan_b_i && (count_o == $past(count_o) + 1) == chan_a_i;
    endproperty
    a_x1: assert property (p_x1) else $error("x1 step wrong");
    property p_save; run_q > 3'h3 && mode_i == 3'h4 && $past(sep_state_o) == 2'h2 &&
        sep_state_o != 2'h2 |-> saved_valid_o && saved_o == $past(count_o) && count_o == 0;
    endproperty
    a_save: assert property (p_save) else $error("save wrong");
    property p_hold; sep_state_o == 2'h3 && arm_i && mode_i == 3'h4
        |=> sep_state_o == 2'h3 && $stable(saved_o) && count_o == 0; endproperty
    a_hold: assert property (p_hold) else $error("single not held");
    property p_push; run_q > 3'h3 && mode_i < 3'h4 && buffered_i && $rose(sample_clk_i)
        |-> ##[1:6] buf_valid_o; endproperty
    a_push: assert property (p_push) else $error("sample not buffered");
    property p_keep; buf_valid_o && !buf_ready_i |=> buf_valid_o; endproperty
    a_keep: assert property (p_keep) else $error("buffer word lost");
    property p_start; $changed(sep_state_o) && sep_state_o == 2'h2
        |-> $past(sep_state_o) == 2'h1; endproperty
    a_start: assert property (p_start) else $error("count without start");
endmodule // cem_counter_chk
bind cem_counter cem_counter_chk #(.CW(CW)) u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .arm_i(arm_i), .mode_i(mode_i), .buffered_i(buffered_i), .reload_en_i(reload_en_i),
    .chan_a_i(chan_a_i), .chan_b_i(chan_b_i), .sample_clk_i(sample_clk_i),
    .buf_ready_i(buf_ready_i), .count_o(count_o), .saved_o(saved_o),
    .saved_valid_o(saved_valid_o), .sep_state_o(sep_state_o), .buf_valid_o(buf_valid_o));

// ---- test/test_counter_encoder_edge_measure.sv ----
// Purpose: self-checking bench for cem_counter
// Assumes: cem_enc_model drives all far-side signals
// Notes: buffer words are checked against a queue of expected values
`timescale 1ns/100ps
module test_counter_encoder_edge_measure;
    reg clock_i, rst_n_i, arm_i, buffered_i;
    reg reload_en_i, start_rising_i, gate_rising_i, source_rising_i;
    reg gate_from_pulse_i, sample_clk_i, buf_ready_i;
    reg [2:0] mode_i;
    reg [1:0] reload_phase_i;
    reg [31:0] reload_value_i, n, head, rnd;
    reg [31:0] exp_q[$];
    wire [6:0] sig;
    wire [31:0] count_o, saved_o, buf_data_o;
    wire [1:0] sep_state_o;
    wire saved_valid_o, overflow_o, buf_valid_o;
    integer miscompares = 0, total_checks = 0, i;
    cem_enc_model enc (.clock_i(clock_i), .sig_o(sig));
    cem_counter uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .arm_i(arm_i), .mode_i(mode_i),
        .buffered_i(buffered_i), .reload_value_i(reload_value_i),
        .reload_phase_i(reload_phase_i), .reload_en_i(reload_en_i),
        .start_rising_i(start_rising_i), .gate_rising_i(gate_rising_i),
        .source_rising_i(source_rising_i), .gate_from_pulse_i(gate_from_pulse_i),
        .chan_a_i(sig[0]), .chan_b_i(sig[1]), .index_i(sig[2]), .start_edge_i(sig[3]),
        .gate_i(sig[4]), .source_i(sig[5]), .neighbour_pulse_i(sig[6]),
        .sample_clk_i(sample_clk_i), .count_o(count_o), .saved_o(saved_o),
        .saved_valid_o(saved_valid_o), .sep_state_o(sep_state_o), .overflow_o(overflow_o),
        .buf_valid_o(buf_valid_o), .buf_ready_i(buf_ready_i), .buf_data_o(buf_data_o));
    // ====================
    // helpers
    task chk(input [31:0] seen, input [31:0] want);
        begin
            total_checks = total_checks + 1;
            if (seen !== want) begin
                miscompares = miscompares + 1;
                $display("BAD %0t got %h want %h", $time, seen, want);
            end
        end
    endtask
    task finish_test;
        begin
            if (miscompares == 0 && total_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task cyc(input integer k);
        begin
            repeat (k) @(posedge clock_i);
            #1;
        end
    endtask
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    initial begin
        #80000;
        miscompares = miscompares + 1;
        finish_test;
    end
    // words leaving the buffer, in order; an extra word can never match
    always @(negedge clock_i) begin
        if (buf_valid_o === 1'b1 && buf_ready_i) begin
            head = exp_q.size() ? exp_q.pop_front() : ~buf_data_o;
            chk(buf_data_o, head);
        end
    end
    // ====================
    // scenarios
    initial begin
        rst_n_i = 1'b0;
        arm_i = 1'b0;
        buffered_i = 1'b0;
        reload_en_i = 1'b0;
        start_rising_i = 1'b1;
        gate_rising_i = 1'b0;
        source_rising_i = 1'b1;
        gate_from_pulse_i = 1'b0;
        sample_clk_i = 1'b0;
        buf_ready_i = 1'b0;
        mode_i = 3'h2;
        reload_phase_i = 2'h0;
        reload_value_i = 32'h0;
        n = 32'h0;
        rnd = $urandom(32'h3AD31B10);
        cyc(8);
        rst_n_i = 1'b1;
        repeat (4) enc.step(1'b1);
        chk(count_o, n);
        arm_i = 1'b1;
        cyc(4);
        for (i = 0; i < 3; i = i + 1) begin
            mode_i = i[2:0];
            repeat (4) enc.step(1'b1);
            n = n + (1 << i);
            chk(count_o, n);
            repeat (4) enc.step(1'b0);
            n = n - (1 << i);
            chk(count_o, n);
        end
        mode_i = 3'h3;
        repeat (3) enc.pulse(0);
        enc.pulse(1);
        chk(count_o, n + 2);
        mode_i = 3'h2;
        reload_value_i = $urandom;
        reload_en_i = 1'b1;
        enc.index_pulse(2'h0);
        chk(count_o, reload_value_i);
        enc.step(1'b1);
        n = reload_value_i + 1;
        chk(count_o, n);
        // second reload in the A high, B low phase
        reload_phase_i = 2'h2;
        reload_value_i = $urandom;
        enc.index_pulse(2'h2);
        chk(count_o, reload_value_i);
        n = reload_value_i;
        // one sample more than the buffer holds, nobody draining
        buffered_i = 1'b1;
        for (i = 0; i < 5; i = i + 1) begin
            if (i == 2) begin
                enc.step(1'b1);
                n = n + 1;
            end
            if (i < 4) exp_q.push_back(n);
            sample_clk_i = 1'b1;
            cyc(4);
            sample_clk_i = 1'b0;
            cyc(4);
        end
        chk(overflow_o, 1);
        for (i = 0; i < 30; i = i + 1) begin
            rnd = $urandom;
            buf_ready_i = rnd[0];
            cyc(1);
        end
        arm_i = 1'b0;
        mode_i = 3'h4;
        buffered_i = 1'b0;
        reload_en_i = 1'b0;
        buf_ready_i = 1'b1;
        cyc(3);
        arm_i = 1'b1;
        cyc(3);
        enc.pulse(3);
        repeat (5) enc.pulse(5);
        enc.pulse(3);
        exp_q.push_back(5);
        enc.pulse(4);
        chk(sep_state_o, 3);
        repeat (2) enc.pulse(5);
        chk(saved_o, 5);
        // buffered, polarities swapped, gate taken from the neighbour pulse
        arm_i = 1'b0;
        buffered_i = 1'b1;
        start_rising_i = 1'b0;
        gate_rising_i = 1'b1;
        source_rising_i = 1'b0;
        gate_from_pulse_i = 1'b1;
        cyc(3);
        arm_i = 1'b1;
        cyc(3);
        enc.pulse(3);
        repeat (3) enc.pulse(5);
        exp_q.push_back(3);
        exp_q.push_back(2);
        enc.pulse(6);
        enc.pulse(5);
        enc.pulse(6);
        repeat (2) enc.pulse(5);
        enc.pulse(4);
        enc.pulse(6);
        cyc(4);
        chk(exp_q.size(), 0);
        finish_test;
    end
endmodule // test_counter_encoder_edge_measure
